// ### sds_far_model.sv
// Far-side model: modulator bit stream and trigger source logic.
`default_nettype none

module sds_far_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Request for one trigger pulse.
  input wire logic fireTrig,
  // Pins toward the sequencer.
  output logic modBit,
  output logic socTrig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lfsr; // Pseudo-random modulator pattern.
  logic [2:0] trigCnt; // Cycles left of the trigger pulse.
  // The pulse lasts four clocks so the two-flop synchroniser sees it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lfsr <= 16'h0001;
      trigCnt <= 3'h0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (fireTrig) begin
        trigCnt <= 3'h4;
      end else if (trigCnt != 3'h0) begin
        trigCnt <= trigCnt - 3'h1;
      end
    end
  end
  assign modBit = lfsr[0];
  assign socTrig = (trigCnt != 3'h0);
endmodule // sds_far_model

`default_nettype wire

// ### sds_pkg.sv
// Package of constants and types for the delta-sigma conversion sequencer.
`default_nettype none

package sds_pkg;

  // ==========================================================================
  // Register bus geometry
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets, one aligned word each.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DECIM = 8'h04;
  localparam logic [7:0] OFS_INSEL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_RES_LSB = 4;
  localparam int CTRL_SHIFT_LSB = 8;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_VALID_BIT = 2;
  localparam int RATIO_W = 9;
  localparam int INSEL_W = 4;
  localparam int SHIFT_W = 5;

  // ==========================================================================
  // Modes, resolutions and states
  // ==========================================================================
  typedef enum logic [1:0] {
    SDS_SINGLE = 2'h0,
    SDS_CONT = 2'h1,
    SDS_MULTI = 2'h2,
    SDS_TURBO = 2'h3
  } sds_mode_t;

  typedef enum logic [1:0] {
    SDS_RES8 = 2'h0,
    SDS_RES12 = 2'h1,
    SDS_RES16 = 2'h2,
    SDS_RES20 = 2'h3
  } sds_res_t;

  // Gray codes along standby, convert, hold.
  typedef enum logic [1:0] {
    SDS_ST_STANDBY = 2'b00,
    SDS_ST_CONVERT = 2'b01,
    SDS_ST_HOLD = 2'b11
  } sds_state_t;

  // ==========================================================================
  // Reset values and counts
  // ==========================================================================
  localparam sds_mode_t MODE_RST = SDS_SINGLE;
  localparam sds_res_t RES_RST = SDS_RES16;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 5'h09;
  localparam logic [RATIO_W-1:0] DECIM_RST = 9'h040;
  localparam logic [INSEL_W-1:0] INSEL_RST = 4'h0;
  localparam logic [2:0] PRIME_OUTPUTS = 3'h4;
  localparam logic [2:0] TURBO_OUTPUTS = 3'h1;
  localparam int MOD_DIV = 32;
  localparam int ACC_W = 40;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sds_bus_t;

  typedef struct packed {
    sds_mode_t mode;
    sds_res_t res;
    logic [SHIFT_W-1:0] shift;
  } sds_cfg_t;

endpackage

`default_nettype wire

// ### sds_seq_asserts.sv
// Port-level timing checks for the conversion sequencer.
`default_nettype none

module sds_seq_asserts (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports.
  input wire sds_pkg::sds_bus_t bus,
  input wire logic [sds_pkg::DATA_W-1:0] rdata,
  input wire logic eocOut,
  input wire logic [sds_pkg::INSEL_W-1:0] inSel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Access shapes
  // A read of the result word; it is the only thing that clears done.
  sequence s_res_rd;
    bus.rd && bus.addr == sds_pkg::OFS_RESULT;
  endsequence
  // A write of the input selection.
  sequence s_sel_wr;
    bus.wr && bus.addr == sds_pkg::OFS_INSEL;
  endsequence
  // ==========================================================
  // Checks
  chk_idle_rdata_zero: assert property (!bus.rd |=> rdata == '0)
    else $error("read data not zero without a read");
  chk_unmapped_zero:
    assert property (bus.rd && bus.addr > sds_pkg::OFS_RESULT |=> rdata == '0)
    else $error("unmapped read not zero");
  chk_sel_follows:
    assert property (s_sel_wr |=> inSel == $past(bus.wdata[3:0]))
    else $error("selection pin did not follow write");
  chk_sel_holds:
    assert property (!(bus.wr && bus.addr == sds_pkg::OFS_INSEL) |=>
      $stable(inSel))
    else $error("selection pin moved without write");
  chk_done_holds:
    assert property (eocOut && !bus.wr && !(bus.rd && bus.addr ==
      sds_pkg::OFS_RESULT) |=> eocOut)
    else $error("done output dropped before result read");
  chk_done_cause:
    assert property ($fell(eocOut) |-> $past(bus.wr) || $past(bus.rd &&
      bus.addr == sds_pkg::OFS_RESULT))
    else $error("done output fell with no cause");
  chk_status_mirror:
    assert property (bus.rd && bus.addr == sds_pkg::OFS_STATUS |=>
      rdata[sds_pkg::STAT_DONE_BIT] == $past(eocOut))
    else $error("status done bit differs from done output");
  chk_ctrl_pulses:
    assert property (bus.rd && bus.addr == sds_pkg::OFS_CTRL |=>
      rdata[1:0] == 2'h0)
    else $error("start or stop bit reads back set");
endmodule // sds_seq_asserts

bind sds_sequencer sds_seq_asserts chk_u (.core_clk(core_clk), .rst(rst),
  .bus(bus), .rdata(rdata), .eocOut(eocOut), .inSel(inSel));

`default_nettype wire

// ### sds_sequencer.sv
// Conversion sequencer: registers, mode control and result hand-off.
// Functional notes
// [R1] Default setting delivers 16-bit results, 48 ksps.
// [R2] Top resolution gives 20-bit results, slow rate.
// [R3] Lower resolutions allow faster output rates.
// [R4] Decimator turns serial bits into words.
// [R5] Filtering has fourth-order sinc response.
// [R6] Decimator sets resolution; output spans four samples.
// [R7] Results invalid until fourth sample after switch.
// [R8] Four modes: single, continuous, multi, turbo.
// [R9] Start bit or trigger input begins conversion.
// [R10] Done flag and output hold until read.
// [R11] Single: standby, then four conversions, three prime.
// [R12] Single: result after fourth, then back to standby.
// [R13] Host polls status or uses done output.
// [R14] Continuous: first result after priming, then steady.
// [R15] Host avoids input switching in continuous mode.
// [R16] Multi: re-prime between samples, auto restart.
// [R17] Turbo: like multi, one reset above sixteen bits.
// [R18] Trigger input optional in continuous mode.
// [R19] Host may drive trigger from logic or clock.
// [R20] Start while busy is ignored.
//
// Our own choices: the address map and the address-and-strobe port.
`default_nettype none

module sds_sequencer #(
  parameter int ACC_W = sds_pkg::ACC_W,
  parameter int MOD_DIV = sds_pkg::MOD_DIV
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register port.
  input wire sds_pkg::sds_bus_t bus,
  output logic [sds_pkg::DATA_W-1:0] rdata,
  // Modulator and trigger pins.
  input wire logic modBit,
  input wire logic socTrig,
  // Done output and input selection.
  output logic eocOut,
  output logic [sds_pkg::INSEL_W-1:0] inSel
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic modMeta; // First stage, read only by modSync.
  logic modSync; // Modulator bit in the core domain.
  logic socMeta; // First stage, read only by socSync.
  logic socSync; // Trigger level in the core domain.
  logic socLast; // Previous trigger level for edge detection.

  // Both pins come from outside this clock's domain, so each passes two
  // flip-flops before anything looks at it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modMeta <= 1'b0;
      modSync <= 1'b0;
      socMeta <= 1'b0;
      socSync <= 1'b0;
      socLast <= 1'b0;
    end else begin
      modMeta <= modBit;
      modSync <= modMeta;
      socMeta <= socTrig;
      socSync <= socMeta;
      socLast <= socSync;
    end
  end

  // A trigger counts on its rising edge only; a pin left low never starts.
  logic socRise;
  assign socRise = socSync && !socLast; // R9 R18

  // ==========================================================================
  // Decimator and its sample-rate enable
  // ==========================================================================
  logic modTick; // One-cycle modulator sample enable.
  logic decClear; // Restarts the decimator from zero.
  logic cicValid; // A new word left the decimator.
  logic signed [ACC_W-1:0] cicData; // That word, full width.
  logic [sds_pkg::RATIO_W-1:0] ratio; // Decimation ratio register.

  sds_tick_div #(
    .DIV(MOD_DIV)
  ) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick(modTick)
  );

  sds_sinc4 #(
    .ACC_W(ACC_W),
    .RATIO_W(sds_pkg::RATIO_W)
  ) u_sinc (
    .core_clk(core_clk),
    .rst(rst),
    .sampleEn(modTick),
    .modBit(modSync),
    .clear(decClear),
    .ratio(ratio),
    .outValid(cicValid),
    .outData(cicData)
  );

  // ==========================================================================
  // Register decode
  // ==========================================================================
  logic wrCtrl;
  logic wrDecim;
  logic wrInsel;
  logic rdResult;
  logic startReq; // Start from either source this cycle.
  logic stopReq; // Software stop of a running sequence.

  assign wrCtrl = bus.wr && (bus.addr == sds_pkg::OFS_CTRL);
  assign wrDecim = bus.wr && (bus.addr == sds_pkg::OFS_DECIM);
  assign wrInsel = bus.wr && (bus.addr == sds_pkg::OFS_INSEL);
  assign rdResult = bus.rd && (bus.addr == sds_pkg::OFS_RESULT);
  assign startReq = (wrCtrl && bus.wdata[sds_pkg::CTRL_START_BIT])
                    || socRise; // R9
  assign stopReq = wrCtrl && bus.wdata[sds_pkg::CTRL_STOP_BIT];

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  sds_pkg::sds_cfg_t cfg; // Mode, resolution and result shift.
  sds_pkg::sds_cfg_t next_cfg;
  logic [sds_pkg::RATIO_W-1:0] next_ratio;
  logic [sds_pkg::INSEL_W-1:0] next_inSel;

  // Software writes steer mode, resolution, ratio and input selection.
  // Changing them mid-sequence is allowed but takes effect at once, so the
  // word in flight may be a mix of the old and new setting.
  always_comb begin
    next_cfg = cfg;
    next_ratio = ratio;
    next_inSel = inSel;
    if (wrCtrl) begin
      next_cfg.mode = sds_pkg::sds_mode_t'(
        bus.wdata[sds_pkg::CTRL_MODE_LSB +: 2]); // R8
      next_cfg.res = sds_pkg::sds_res_t'(
        bus.wdata[sds_pkg::CTRL_RES_LSB +: 2]); // R6
      next_cfg.shift = bus.wdata[sds_pkg::CTRL_SHIFT_LSB +: sds_pkg::SHIFT_W];
    end
    if (wrDecim) begin
      next_ratio = bus.wdata[sds_pkg::RATIO_W-1:0]; // R3 R6
    end
    if (wrInsel) begin
      next_inSel = bus.wdata[sds_pkg::INSEL_W-1:0];
    end
  end

  // Register the configuration; reset gives 16-bit single mode.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg.mode <= sds_pkg::MODE_RST;
      cfg.res <= sds_pkg::RES_RST; // R1
      cfg.shift <= sds_pkg::SHIFT_RST;
      ratio <= sds_pkg::DECIM_RST;
      inSel <= sds_pkg::INSEL_RST;
    end else begin
      cfg <= next_cfg;
      ratio <= next_ratio;
      inSel <= next_inSel;
    end
  end

  // ==========================================================================
  // Result formatting
  // ==========================================================================
  // Shift the raw word down and keep the chosen number of signed bits.
  function automatic logic [31:0] fmtResult(
    input logic signed [ACC_W-1:0] raw,
    input logic [sds_pkg::SHIFT_W-1:0] sh,
    input sds_pkg::sds_res_t res
  );
    logic signed [ACC_W-1:0] scaled;
    scaled = raw >>> sh;
    case (res)
      sds_pkg::SDS_RES8: fmtResult = 32'(signed'(scaled[7:0]));
      sds_pkg::SDS_RES12: fmtResult = 32'(signed'(scaled[11:0]));
      sds_pkg::SDS_RES16: fmtResult = 32'(signed'(scaled[15:0]));
      default: fmtResult = 32'(signed'(scaled[19:0]));
    endcase
  endfunction

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  sds_pkg::sds_state_t state; // Standby, converting or holding a result.
  logic [2:0] convCnt; // Words since the last decimator clear.
  logic [2:0] validCnt; // Words since the last input switch.
  logic done; // Result waiting to be read.
  logic [31:0] result; // Latest result word.
  sds_pkg::sds_state_t next_state;
  logic [2:0] next_convCnt;
  logic [2:0] next_validCnt;
  logic next_done;
  logic [31:0] next_result;
  logic next_decClear;
  logic [2:0] needCnt; // Words needed before a result counts.
  logic [2:0] convInc; // convCnt after this word, saturating.
  logic resultNow; // This word becomes a result.
  logic turboFast; // Turbo mode above sixteen bits.

  assign turboFast = (cfg.mode == sds_pkg::SDS_TURBO)
                     && (cfg.res == sds_pkg::SDS_RES20); // R17
  assign needCnt = turboFast ? sds_pkg::TURBO_OUTPUTS
                             : sds_pkg::PRIME_OUTPUTS; // R6 R11 R14
  assign convInc = (convCnt == sds_pkg::PRIME_OUTPUTS) ? convCnt
                                                       : convCnt + 3'h1;
  assign resultNow = (state == sds_pkg::SDS_ST_CONVERT) && cicValid
                     && (convInc >= needCnt) && !decClear;

  // Next-state logic for the whole conversion sequence. The decimator is
  // cleared on every start; a word that leaves it in the clear cycle was
  // built from stale bits and is not counted toward priming.
  always_comb begin
    next_state = state;
    next_convCnt = convCnt;
    next_validCnt = validCnt;
    next_done = done;
    next_result = result;
    next_decClear = 1'b0;
    // Reading the result frees the done flag; a new result wins below.
    if (rdResult) begin
      next_done = 1'b0; // R10
    end
    // Count words since the input switch, saturating at four.
    if (wrInsel) begin
      next_validCnt = 3'h0; // R7
    end else if (cicValid && validCnt != sds_pkg::PRIME_OUTPUTS) begin
      next_validCnt = validCnt + 3'h1; // R7
    end
    case (state)
      sds_pkg::SDS_ST_STANDBY: begin
        // Only standby accepts a start; elsewhere a start is dropped.
        if (startReq && !stopReq) begin // R9 R20
          next_state = sds_pkg::SDS_ST_CONVERT;
          next_convCnt = 3'h0;
          next_decClear = 1'b1; // R11
        end
      end
      sds_pkg::SDS_ST_CONVERT: begin
        if (stopReq) begin
          next_state = sds_pkg::SDS_ST_STANDBY;
        end else if (cicValid && !decClear) begin // R11
          next_convCnt = convInc; // R11 R14
          if (resultNow) begin
            next_result = fmtResult(cicData, cfg.shift, cfg.res); // R2
            next_done = 1'b1; // R10
            case (cfg.mode)
              sds_pkg::SDS_SINGLE: begin
                next_state = sds_pkg::SDS_ST_HOLD; // R12
              end
              sds_pkg::SDS_CONT: begin
                next_state = sds_pkg::SDS_ST_CONVERT; // R14
              end
              default: begin
                // Multi and turbo restart from a clean decimator.
                next_convCnt = 3'h0; // R16 R17
                next_decClear = 1'b1; // R16 R17
              end
            endcase
          end
        end
      end
      sds_pkg::SDS_ST_HOLD: begin
        // Single mode waits here until the word has been taken or a stop is written.
        if (rdResult || stopReq) begin
          next_state = sds_pkg::SDS_ST_STANDBY; // R12
        end
      end
      default: begin
        next_state = sds_pkg::SDS_ST_STANDBY;
      end
    endcase
  end

  // Register the sequencer state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= sds_pkg::SDS_ST_STANDBY;
      convCnt <= 3'h0;
      validCnt <= 3'h0;
      done <= 1'b0;
      result <= 32'h0000_0000;
      decClear <= 1'b0;
    end else begin
      state <= next_state;
      convCnt <= next_convCnt;
      validCnt <= next_validCnt;
      done <= next_done;
      result <= next_result;
      decClear <= next_decClear;
    end
  end

  // The done pin mirrors the sticky flag so DMA or an interrupt can use it.
  assign eocOut = done; // R10 R13

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [31:0] next_rdata;

  // Read data stands in the cycle after the strobe and is zero otherwise.
  // Unmapped offsets read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        sds_pkg::OFS_CTRL: begin
          next_rdata[sds_pkg::CTRL_MODE_LSB +: 2] = cfg.mode;
          next_rdata[sds_pkg::CTRL_RES_LSB +: 2] = cfg.res;
          next_rdata[sds_pkg::CTRL_SHIFT_LSB +: sds_pkg::SHIFT_W] = cfg.shift;
        end
        sds_pkg::OFS_DECIM: begin
          next_rdata[sds_pkg::RATIO_W-1:0] = ratio;
        end
        sds_pkg::OFS_INSEL: begin
          next_rdata[sds_pkg::INSEL_W-1:0] = inSel;
        end
        sds_pkg::OFS_STATUS: begin
          next_rdata[sds_pkg::STAT_DONE_BIT] = done; // R13
          next_rdata[sds_pkg::STAT_BUSY_BIT] =
            (state != sds_pkg::SDS_ST_STANDBY);
          next_rdata[sds_pkg::STAT_VALID_BIT] =
            (validCnt == sds_pkg::PRIME_OUTPUTS); // R7
        end
        sds_pkg::OFS_RESULT: begin
          next_rdata = result;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register the read data.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule // sds_sequencer

`default_nettype wire

// ### sds_sequencer_tb.sv
// Self-checking testbench for the conversion sequencer.
`default_nettype none

module sds_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MD = 2; // Short divider keeps the run brief.
  localparam int P = MD * 4; // Clocks per decimator word at ratio 4.
  logic core_clk, rst, modBit, socTrig, eocOut, fireTrig;
  sds_pkg::sds_bus_t bus;
  logic [31:0] rdata, rv;
  logic [3:0] inSel;
  logic [15:0] rnd;
  int mismatches, total_checks, cyc, t0, k;
  int md[6] = '{0, 0, 1, 2, 3, 3};
  int rs[6] = '{2, 1, 1, 0, 3, 2};

  sds_sequencer #(.MOD_DIV(MD)) dut_u (.core_clk(core_clk), .rst(rst),
    .bus(bus), .rdata(rdata), .modBit(modBit), .socTrig(socTrig),
    .eocOut(eocOut), .inSel(inSel));
  sds_far_model far_u (.core_clk(core_clk), .rst(rst),
    .fireTrig(fireTrig), .modBit(modBit), .socTrig(socTrig));

  // ==========================================================
  // Clock, cycle count and helpers
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Control word with shift 9 and the chosen mode and resolution.
  function automatic logic [31:0] ctrl_word(int m, int r, int go);
    return 32'((9 << 8) | (r << 4) | (m << 2) | go);
  endfunction
  // Decimator words one result needs; turbo at 20 bits skips priming.
  function automatic int words(int m, int r, int first);
    if (m == 3 && r == 3) return 1;
    if (m == 1 && first == 0) return 1;
    return 4;
  endfunction
  // True when the upper bits are a copy of the sign of a w-bit result.
  function automatic logic [31:0] sext_ok(logic [31:0] r, int w);
    logic [31:0] m;
    m = 32'hFFFFFFFF << (w - 1);
    return 32'((r & m) === 32'h0 || (r & m) === m);
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus_w(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bus.wr <= 1'b0;
    #1;
  endtask
  task automatic bus_r(logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait for done; a hang counts as a mismatch.
  task automatic wait_eoc(int lim);
    while (eocOut !== 1'b1 && cyc - t0 < lim) begin
      @(posedge core_clk) #1;
    end
    check("done seen", eocOut, 1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    bus = '0;
    fireTrig = 1'b0;
    rnd = 16'h0001;
    cyc = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    bus_r(sds_pkg::OFS_CTRL, rv);
    check("ctrl reset", rv, 32'h920);
    bus_r(sds_pkg::OFS_DECIM, rv);
    check("ratio reset", rv, 32'h40);
    bus_r(8'h14, rv);
    check("unmapped read", rv, 32'h0);
    bus_w(sds_pkg::OFS_DECIM, 32'h4);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr_next(rnd);
      bus_w(sds_pkg::OFS_INSEL, {28'h0, rnd[3:0]});
      check("selection pin", inSel, rnd[3:0]);
      bus_r(sds_pkg::OFS_STATUS, rv);
      check("valid after switch", rv[2], 1'b0);
      t0 = cyc;
      bus_w(sds_pkg::OFS_CTRL, ctrl_word(md[i], rs[i], i != 1));
      if (i == 1) begin
        @(posedge core_clk) fireTrig <= 1'b1;
        @(posedge core_clk) fireTrig <= 1'b0;
      end
      wait_eoc(3000);
      k = words(md[i], rs[i], 1);
      check("first time", 32'(cyc - t0 >= (k - 1) * P &&
        cyc - t0 <= (k + 1) * P + 12), 1);
      t0 = cyc;
      bus_w(sds_pkg::OFS_CTRL, ctrl_word(md[i], rs[i], 1));
      bus_r(sds_pkg::OFS_STATUS, rv);
      check("done and valid", rv[2:0] & 3'h5,
        (k == 4) ? 32'h5 : 32'h1);
      bus_r(sds_pkg::OFS_RESULT, rv);
      check("sign copy", sext_ok(rv, 8 + 4 * rs[i]), 1);
      if (md[i] == 0) begin
        check("done cleared", eocOut, 1'b0);
        repeat (6 * P) @(posedge core_clk);
        check("standby after read", eocOut, 1'b0);
      end else begin
        wait_eoc(200);
        k = words(md[i], rs[i], 0);
        check("next gap", 32'(cyc - t0 >= k * P - 3 &&
          cyc - t0 <= k * P + 3), 1);
        bus_w(sds_pkg::OFS_CTRL, ctrl_word(md[i], rs[i], 0) | 32'h2);
        bus_r(sds_pkg::OFS_RESULT, rv);
        repeat (6 * P) @(posedge core_clk);
        check("stopped", eocOut, 1'b0);
      end
    end
    stop_test();
  end

  // Watchdog well beyond the expected run of under a thousand cycles.
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule // sds_sequencer_tb

`default_nettype wire

// ### sds_sinc4.sv
// Fourth-order sinc decimator turning the modulator bit stream into words.
`default_nettype none

module sds_sinc4 #(
  parameter int ACC_W = 40,
  parameter int RATIO_W = 9
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Bit stream in.
  input wire logic sampleEn,
  input wire logic modBit,
  input wire logic clear,
  input wire logic [RATIO_W-1:0] ratio,
  // Words out.
  output logic outValid,
  output logic signed [ACC_W-1:0] outData
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic signed [ACC_W-1:0] integ [4]; // Integrator chain.
  logic signed [ACC_W-1:0] dly [4]; // Comb delay taps.
  logic [RATIO_W-1:0] phase; // Position in the decimation period.
  logic signed [ACC_W-1:0] next_integ [4];
  logic signed [ACC_W-1:0] next_dly [4];
  logic [RATIO_W-1:0] next_phase;
  logic next_outValid;
  logic signed [ACC_W-1:0] next_outData;
  logic signed [ACC_W-1:0] inVal;
  logic signed [ACC_W-1:0] stage;

  // Four integrators at the modulator rate, four combs at the word rate.
  // Wrap-around arithmetic is fine: the combs undo any integrator overflow
  // as long as ACC_W covers four times log2 of the ratio plus one.
  always_comb begin
    next_integ = integ;
    next_dly = dly;
    next_phase = phase;
    next_outValid = 1'b0;
    next_outData = outData;
    stage = integ[3];
    inVal = modBit ? ACC_W'(1) : {ACC_W{1'b1}};
    if (clear) begin
      // A fresh start forgets every earlier bit.
      for (int k = 0; k < 4; k++) begin
        next_integ[k] = '0;
        next_dly[k] = '0;
      end
      next_phase = '0;
    end else if (sampleEn) begin
      next_integ[0] = integ[0] + inVal; // R4
      for (int k = 1; k < 4; k++) begin
        next_integ[k] = integ[k] + integ[k-1]; // R5
      end
      next_phase = phase + RATIO_W'(1);
      // Greater-or-equal so a smaller ratio written mid-run wraps at once.
      if (phase >= ratio - RATIO_W'(1)) begin
        next_phase = '0;
        for (int k = 0; k < 4; k++) begin
          next_dly[k] = stage;
          stage = stage - dly[k]; // R5
        end
        next_outData = stage; // R4
        next_outValid = 1'b1;
      end
    end
  end

  // Register the filter state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 4; k++) begin
        integ[k] <= '0;
        dly[k] <= '0;
      end
      phase <= '0;
      outValid <= 1'b0;
      outData <= '0;
    end else begin
      integ <= next_integ;
      dly <= next_dly;
      phase <= next_phase;
      outValid <= next_outValid;
      outData <= next_outData;
    end
  end

endmodule // sds_sinc4

`default_nettype wire

// ### sds_tick_div.sv
// Divider that makes the modulator sample-rate enable pulse.
`default_nettype none

module sds_tick_div #(
  parameter int DIV = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // One-cycle enable every DIV clocks.
  output logic tick
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  logic [15:0] count; // Cycles since the last tick.
  logic [15:0] next_count;
  logic next_tick;

  // Count up through the period and pulse at the wrap.
  always_comb begin
    next_tick = 1'b0;
    next_count = count + 16'h0001;
    if (count == 16'(DIV - 1)) begin
      next_count = 16'h0000;
      next_tick = 1'b1;
    end
  end

  // Register the counter and the pulse.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule // sds_tick_div

`default_nettype wire
